// ### rtl/stro_params.svh
// Contract
// RL1: Serializer words aligned to serializer parallel clock
// RL2: Retiming FIFO holds sixteen twenty-bit words
// RL3: HD writes every video clock, reads every cycle
// RL4: SD width converter writes on alternate video clocks
// RL5: SD reads every fifth or eleventh serializer cycle
// RL6: SD repeats every bit five times
// RL7: Triple-standard SD repeats every bit eleven times
// RL8: Optional HD mode doubles every bit
// RL9: Serializer path carries twenty-bit words
// RL10: Video clock rate set by the source
// RL11: Start reading after a few words, no slips (the code lets slips happen and only flags them, sticky, in stat)
`ifndef STRO_PARAMS_SVH
`define STRO_PARAMS_SVH

// ****************************************************************
// Widths and depths
// ****************************************************************
`define STRO_WORD_W 20
`define STRO_HALF_W 10
`define STRO_FIFO_DEPTH 16
`define STRO_FIFO_AW 4
`define STRO_OBUF_DEPTH 2
`define STRO_OBUF_AW 1

// ****************************************************************
// Cadence and start-up
// ****************************************************************
`define STRO_REP_HD 4'd1
`define STRO_REP_HD2X 4'd2
`define STRO_REP_SD 4'd5
`define STRO_REP_TRI 4'd11
`define STRO_START_LEVEL 5'd4

`endif

// ### rtl/stro_pkg.sv
`default_nettype none
package stro_pkg;

    // Output standard chosen by the user
    typedef enum logic [1:0] {
        STRO_HD,
        STRO_HD2X,
        STRO_SD,
        STRO_TRI
    } stro_mode_t;

    typedef logic [19:0] stro_word_t;

    // Health of the retiming path
    typedef struct packed {
        logic started;
        logic overflow;
        logic underflow;
    } stro_stat_t;

endpackage
`default_nettype wire

// ### rtl/stro_fifo.sv
`include "stro_params.svh"
`default_nettype none
module stro_fifo #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire stro_pkg::stro_word_t in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output stro_pkg::stro_word_t out_data,
    // Fill level
    output logic [AW:0] level
);

    stro_pkg::stro_word_t mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest flags straight from the count
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign level = cnt_r;

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule
`default_nettype wire

// ### rtl/stro_top.sv
`include "stro_params.svh"
`default_nettype none
module stro_top (
    // Serializer parallel clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Video side, from another clock
    input wire logic vid_clk,
    input wire stro_pkg::stro_word_t vid_data,
    input wire logic [1:0] mode_sel,
    // Serializer side
    output stro_pkg::stro_word_t ser_data,
    output logic ser_valid,
    input wire logic ser_ready,
    // Status
    output stro_pkg::stro_stat_t stat
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic vclk_s1_r, vclk_s2_r, vclk_s3_r;
    stro_pkg::stro_word_t vdat_s1_r, vdat_s2_r;
    logic [1:0] mode_s1_r, mode_s2_r;

    // Two stages on every pin; a third vclk stage feeds the edge finder
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vclk_s1_r <= 1'b0;
            vclk_s2_r <= 1'b0;
            vclk_s3_r <= 1'b0;
            vdat_s1_r <= '0;
            vdat_s2_r <= '0;
            mode_s1_r <= 2'h0;
            mode_s2_r <= 2'h0;
        end
        else
        begin
            vclk_s1_r <= vid_clk;
            vclk_s2_r <= vclk_s1_r;
            vclk_s3_r <= vclk_s2_r;
            vdat_s1_r <= vid_data;
            vdat_s2_r <= vdat_s1_r;
            mode_s1_r <= mode_sel;
            mode_s2_r <= mode_s1_r;
        end
    end

    // Data is sampled half a video period after it settles, so the slow video
    // clock (RL10 sets its rate) leaves ample margin for the edge.
    wire vid_edge = vclk_s2_r && !vclk_s3_r;
    wire stro_pkg::stro_mode_t mode = stro_pkg::stro_mode_t'(mode_s2_r);
    wire is_sd = (mode == stro_pkg::STRO_SD) || (mode == stro_pkg::STRO_TRI);

    // ****************************************************************
    // SD width conversion
    // ****************************************************************
    logic half_r;
    logic [`STRO_HALF_W-1:0] lo_r;

    // First ten-bit word goes in the low half, sent first
    wire stro_pkg::stro_word_t wr_word =
        is_sd ? {vdat_s2_r[`STRO_HALF_W-1:0], lo_r} : vdat_s2_r;
    wire wr_req = vid_edge && (!is_sd || half_r); // RL3 RL4

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            half_r <= 1'b0;
            lo_r <= '0;
        end
        else if (vid_edge && is_sd)
        begin
            half_r <= !half_r; // RL4
            lo_r <= vdat_s2_r[`STRO_HALF_W-1:0];
        end
    end

    // ****************************************************************
    // Retiming FIFO
    // ****************************************************************
    logic rf_ready, rf_valid, rf_pop;
    stro_pkg::stro_word_t rf_data;
    logic [`STRO_FIFO_AW:0] rf_level;

    // RL2
    stro_fifo #(
        .DEPTH(`STRO_FIFO_DEPTH),
        .AW(`STRO_FIFO_AW)
    ) u_retime (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(wr_req),
        .in_ready(rf_ready),
        .in_data(wr_word),
        .out_valid(rf_valid),
        .out_ready(rf_pop),
        .out_data(rf_data),
        .level(rf_level)
    );

    // ****************************************************************
    // Oversampler
    // ****************************************************************
    // Bit j of output word ph is source bit (ph*20+j)/rep
    function automatic stro_pkg::stro_word_t expand(
        input stro_pkg::stro_word_t w,
        input logic [3:0] ph,
        input stro_pkg::stro_mode_t md
    );
        stro_pkg::stro_word_t o;
        int pos;
        int idx;
        o = '0;
        for (int j = 0; j < `STRO_WORD_W; j++)
        begin
            pos = int'(ph) * `STRO_WORD_W + j;
            case (md)
                stro_pkg::STRO_HD2X: idx = pos / 2; // RL8
                stro_pkg::STRO_SD: idx = pos / 5; // RL6
                stro_pkg::STRO_TRI: idx = pos / 11; // RL7
                default: idx = pos;
            endcase
            o[j] = w[idx % `STRO_WORD_W];
        end
        return o;
    endfunction

    function automatic logic [3:0] reps(input stro_pkg::stro_mode_t md);
        case (md)
            stro_pkg::STRO_HD2X: reps = `STRO_REP_HD2X;
            stro_pkg::STRO_SD: reps = `STRO_REP_SD;
            stro_pkg::STRO_TRI: reps = `STRO_REP_TRI;
            default: reps = `STRO_REP_HD;
        endcase
    endfunction

    stro_pkg::stro_word_t hold_r;
    logic hold_v_r;
    logic [3:0] phase_r;
    logic started_r, ovf_r, udf_r;
    logic ob_ready, ob_valid;
    stro_pkg::stro_word_t ob_data;
    logic ob_take;

    // A word is spread over reps() serializer words, so the FIFO is read
    // once per that many cycles; a full output buffer stalls the cadence.
    wire adv = hold_v_r && ob_ready;
    wire last = (phase_r == reps(mode) - 4'd1);
    wire need = !hold_v_r || (adv && last);
    assign rf_pop = need && started_r && rf_valid; // RL3 RL5 RL11
    wire stro_pkg::stro_word_t ob_in = expand(hold_r, phase_r, mode);

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hold_r <= '0;
            hold_v_r <= 1'b0;
            phase_r <= 4'h0;
        end
        else
        begin
            if (rf_pop)
            begin
                hold_r <= rf_data;
                hold_v_r <= 1'b1;
                phase_r <= 4'h0;
            end
            else if (adv)
            begin
                hold_v_r <= !last;
                phase_r <= last ? 4'h0 : phase_r + 4'h1;
            end
        end
    end

    // Reading waits for a cushion of words; slips are flagged and sticky
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            started_r <= 1'b0;
            ovf_r <= 1'b0;
            udf_r <= 1'b0;
        end
        else
        begin
            if (rf_level >= `STRO_START_LEVEL)
                started_r <= 1'b1; // RL11
            if (wr_req && !rf_ready)
                ovf_r <= 1'b1; // RL11
            if (need && started_r && !rf_valid)
                udf_r <= 1'b1; // RL11
        end
    end

    // ****************************************************************
    // Output buffer and serializer register
    // ****************************************************************
    // Move a word on whenever the serializer register is free or taken
    assign ob_take = ob_valid && (!ser_valid || ser_ready);

    stro_fifo #(
        .DEPTH(`STRO_OBUF_DEPTH),
        .AW(`STRO_OBUF_AW)
    ) u_obuf (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(hold_v_r),
        .in_ready(ob_ready),
        .in_data(ob_in),
        .out_valid(ob_valid),
        .out_ready(ob_take),
        .out_data(ob_data),
        .level()
    );

    // One whole twenty-bit word per serializer clock, from a flop
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ser_data <= '0;
            ser_valid <= 1'b0;
            stat <= '0;
        end
        else
        begin
            if (ob_take)
                ser_data <= ob_data; // RL1 RL9
            if (ob_take)
                ser_valid <= 1'b1;
            else if (ser_ready)
                ser_valid <= 1'b0;
            stat <= '{started: started_r, overflow: ovf_r,
                      underflow: udf_r};
        end
    end

endmodule
`default_nettype wire

// ### dv/stro_top_asserts.sv
`default_nettype none
module stro_top_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Watched ports
    input wire logic [1:0] mode_sel,
    input wire stro_pkg::stro_word_t ser_data,
    input wire logic ser_valid,
    input wire logic ser_ready,
    input wire stro_pkg::stro_stat_t stat
);
    timeunit 1ns;
    timeprecision 1ps;
    // True when every run of n bits is uniform
    function automatic logic runs_ok(stro_pkg::stro_word_t w, int n);
        logic ok;
        ok = 1'b1;
        for (int i = 1; i < 20; i++)
            if (i % n != 0 && w[i] != w[i-1])
                ok = 1'b0;
        return ok;
    endfunction

    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_word_holds:
        assert property (ser_valid && !ser_ready |=> $stable(ser_data))
        else $error("word changed while stalled");
    a_valid_holds:
        assert property (ser_valid && !ser_ready |=> ser_valid)
        else $error("valid dropped while stalled");
    a_no_early_word:
        assert property (ser_valid |-> stat.started)
        else $error("word offered before start");
    a_start_kept:
        assert property (!$fell(stat.started))
        else $error("started flag fell");
    a_overflow_kept:
        assert property (stat.overflow |=> stat.overflow)
        else $error("overflow flag fell");
    a_underflow_kept:
        assert property (!$fell(stat.underflow))
        else $error("underflow flag fell");
    a_sd_runs:
        assert property (mode_sel == 2'h2 && ser_valid
            |-> runs_ok(ser_data, 5))
        else $error("SD word not in runs of five");
    a_hd2x_pairs:
        assert property (mode_sel == 2'h1 && ser_valid
            |-> runs_ok(ser_data, 2))
        else $error("HD2x word not in pairs");
endmodule
`default_nettype wire

// ### dv/stro_ser_sink.sv
`default_nettype none
module stro_ser_sink (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Serializer side
    input wire stro_pkg::stro_word_t ser_data,
    input wire logic ser_valid,
    output logic ser_ready,
    // Pace: 0 prompt, 1 every other cycle, 2 stopped
    input wire logic [1:0] pace
);
    timeunit 1ns;
    timeprecision 1ps;
    stro_pkg::stro_word_t got[$];
    logic tick;

    // Take a word where both agree; ready only moves after that edge
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ser_ready <= 1'b0;
            tick <= 1'b0;
        end
        else
        begin
            if (ser_valid && ser_ready)
                got.push_back(ser_data);
            tick <= ~tick;
            ser_ready <= (pace == 2'h0) || (pace == 2'h1 && tick);
        end
    end
endmodule
`default_nettype wire

// ### dv/stro_top_tb_top.sv
`default_nettype none
module stro_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic vgen = 1'b0;
    logic vid_en = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic [1:0] pace = 2'h0;
    stro_pkg::stro_word_t vid_data = 20'h00000;
    stro_pkg::stro_word_t ser_data;
    logic ser_valid;
    logic ser_ready;
    stro_pkg::stro_stat_t stat;
    wire logic vid_clk;
    int failures = 0;
    int compares = 0;
    bit src[$];

    // Video clock has its own phase; gated only while low, so no runt
    always #12.5 ref_clk = ~ref_clk;
    always #100 vgen = ~vgen;
    assign vid_clk = vgen & vid_en;

    stro_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .vid_clk(vid_clk),
        .vid_data(vid_data), .mode_sel(mode_sel), .ser_data(ser_data),
        .ser_valid(ser_valid), .ser_ready(ser_ready), .stat(stat));
    stro_ser_sink sink (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ser_data(ser_data), .ser_valid(ser_valid),
        .ser_ready(ser_ready), .pace(pace));

    // ********
    // Tasks
    // ********
    task automatic check(string what, logic [19:0] exp, logic [19:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Mode may only change under reset
    task automatic restart(logic [1:0] md, logic [1:0] pc);
        sys_rst <= 1'b1;
        mode_sel <= md;
        pace <= pc;
        repeat (2) @(posedge ref_clk);
        sink.got.delete();
        src.delete();
        sys_rst <= 1'b0;
    endtask

    // Data moves a half period before each rise, well clear of sampling
    task automatic send(int n, logic [1:0] md);
        stro_pkg::stro_word_t w;
        for (int i = 0; i < n; i++)
        begin
            @(negedge vgen);
            w = 20'h5a3c6 ^ (20'h0b71d * 20'(i));
            vid_data <= w;
            vid_en <= 1'b1;
            for (int b = 0; b < (md[1] ? 10 : 20); b++)
                src.push_back(w[b]);
        end
        @(negedge vgen);
        vid_en <= 1'b0;
    endtask

    // Serial bit i must be source bit i / repeat, LSB first
    task automatic t_stream(logic [1:0] md, logic [1:0] pc, int n);
        int reps[4] = '{1, 2, 5, 11};
        int nw;
        int k;
        logic [19:0] exp;
        restart(md, pc);
        send(n, md);
        nw = src.size() * reps[md] / 20;
        k = 0;
        while (sink.got.size() < nw && k < 4000)
        begin
            @(posedge ref_clk);
            k++;
        end
        check("word count", 20'(nw), 20'(sink.got.size()));
        if (k >= 4000)
            finish_test();
        for (int w = 0; w < nw; w++)
        begin
            for (int j = 0; j < 20; j++)
                exp[j] = src[(20 * w + j) / reps[md]];
            check("serial word", exp, sink.got[w]);
        end
        check("started", 20'h1, 20'(stat.started));
        check("no overflow", 20'h0, 20'(stat.overflow));
        // Source is slower than the drain, so the store runs dry at the end
        check("underflow", 20'h1, 20'(stat.underflow));
        $display("stream test mode %0d pace %0d done", md, pc);
    endtask

    // Serializer never ready: retiming store fills and refuses
    task automatic t_overflow();
        restart(2'h0, 2'h2);
        send(28, 2'h0);
        repeat (8) @(posedge ref_clk);
        check("overflow", 20'h1, 20'(stat.overflow));
        // Stalled holder never asks for a word, so no underflow
        check("no underflow", 20'h0, 20'(stat.underflow));
        check("held word", 20'h5a3c6, ser_data);
        check("held valid", 20'h1, 20'(ser_valid));
        $display("overflow test done");
    endtask

    initial
    begin
        t_stream(2'h0, 2'h0, 12);
        t_stream(2'h1, 2'h0, 12);
        t_stream(2'h2, 2'h0, 12);
        t_stream(2'h3, 2'h0, 12);
        t_stream(2'h2, 2'h1, 12);
        t_overflow();
        finish_test();
    end
endmodule

bind stro_top stro_top_asserts u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mode_sel(mode_sel), .ser_data(ser_data), .ser_valid(ser_valid),
    .ser_ready(ser_ready), .stat(stat));
`default_nettype wire
